// file: pcsr_regs.sv
// Operation
// - Live status bit 5 reads one while charge calibration runs.
// - Overheat and low-supply live bits refresh only with nonzero sampling period.
// - Rail C regulation bit valid only with linear C on, not paralleled.
// - Rail B and rail A regulation bits valid only with their switcher on.
// - Calibration counts two to the power of field plus one pulses.
// - Calibration pulse count ignores the charge prescaler.
// - Load target field routes calibration load to none, A, B or C.
// - Load level codes 0-3 pick low range, 4-7 high range.
// - Fuse address register holds seven bits; bit 7 reserved.
// - Writing read bit starts fuse read; busy bit holds until done.
// - Fuse data register shows last fuse read byte, resets to zero.
// - Command bit 7 starts one supply-voltage conversion.
// - Command bit 6 loads next conversion directly into result registers.
// - Command bit 5 clears every charge counter.
// - Command bit 4 starts a charge calibration.
// - Command bit 2 rereads fuses, restoring control registers to defaults.
// - Command bit 0 forces a full reset like a brownout.
// - Single-cell flag latched at power-on from the auxiliary supply pin.
// - Mode bit 2 reports switcher B buck or linear mode.
// - Mode bits 1:0 report switcher A buck, buck-boost or boost.
// - Mode register updates freeze while a read addresses it.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "pcsr_consts.svh"
module pcsr_regs #(
    parameter int ADDR_W = 12,
    parameter logic [2:0] REVISION_CODE = 3'h2, // Arbitrary value.
    parameter logic [4:0] PART_CODE = 5'h0A // Arbitrary value.
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_b_in,
    // AXI4-Lite write channels.
    input wire logic axi_awvalid_in,
    output logic axi_awready_out,
    input wire logic [ADDR_W-1:0] axi_awaddr_in,
    input wire logic axi_wvalid_in,
    output logic axi_wready_out,
    input wire logic [31:0] axi_wdata_in,
    input wire logic [3:0] axi_wstrb_in,
    output logic axi_bvalid_out,
    input wire logic axi_bready_in,
    output logic [1:0] axi_bresp_out,
    // AXI4-Lite read channels.
    input wire logic axi_arvalid_in,
    output logic axi_arready_out,
    input wire logic [ADDR_W-1:0] axi_araddr_in,
    output logic axi_rvalid_out,
    input wire logic axi_rready_in,
    output logic [31:0] axi_rdata_out,
    output logic [1:0] axi_rresp_out,
    // Settings from neighbouring control logic.
    input wire logic [7:0] sampling_period_in,
    input wire logic linear_reg_c_en_in,
    input wire logic parallel_c_with_a_in,
    input wire logic switcher_a_en_in,
    input wire logic switcher_b_en_in,
    // Analog comparator and converter pins.
    input wire logic overheat_pin_in,
    input wire logic supply_low_pin_in,
    input wire logic rail_a_regulating_pin_in,
    input wire logic rail_b_regulating_pin_in,
    input wire logic rail_c_regulating_pin_in,
    input wire logic cal_pulse_pin_in,
    input wire logic aux_supply_pin_in,
    input wire logic rail_b_converter_mode_pin_in,
    input wire logic [1:0] rail_a_converter_mode_pin_in,
    // Fuse burn port.
    input wire logic fuse_prog_en_in,
    input wire logic [7:0] fuse_prog_data_in,
    // Command pulses.
    output logic conv_start_out,
    output logic conversion_result_reload_out,
    output logic charge_counters_clear_out,
    output logic charge_cal_go_out,
    output logic fuse_reload_out,
    output logic full_reset_out,
    // Calibration load drive.
    output logic cal_active_out,
    output logic [1:0] cal_load_target_out,
    output logic [2:0] cal_load_level_out,
    output logic cal_load_high_out
);
    pcsr_pkg::pcsr_state_t s_q;
    pcsr_pkg::pcsr_state_t s_d;
    logic [7:0] fuse_rd_data;
    logic [7:0] live_view;
    logic [8:0] cal_goal;
    logic mode_freeze;
    logic wr_fire;

    function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
        idx_of = a[`PCSR_IDX_MSB:`PCSR_IDX_LSB];
    endfunction

    function automatic logic [8:0] pulse_goal(input logic [2:0] e);
        pulse_goal = 9'h001 << ({1'b0, e} + 4'h1);
    endfunction

    function automatic logic is_mapped(input logic [7:0] i);
        is_mapped = (i == `PCSR_IDX_LIVE) || (i == `PCSR_IDX_ID) || (i == `PCSR_IDX_CAL) ||
            (i == `PCSR_IDX_FADDR) || (i == `PCSR_IDX_FDATA) || (i == `PCSR_IDX_FSTAT) ||
            (i == `PCSR_IDX_CMD) || (i == `PCSR_IDX_MODE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    pcsr_fuse_mem #(
        .AW(7),
        .DW(8)
    ) u_fuse_mem (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .wr_en_in(fuse_prog_en_in),
        .wr_addr_in(s_q.fuse_addr),
        .wr_data_in(fuse_prog_data_in),
        .rd_en_in(s_q.fuse_st == pcsr_pkg::PCSR_F_READ),
        .rd_addr_in(s_q.fuse_addr),
        .rd_data_out(fuse_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    assign axi_awready_out = !s_q.aw_got && !s_q.bvalid;
    assign axi_wready_out = !s_q.w_got && !s_q.bvalid;
    assign axi_arready_out = !s_q.rvalid;
    assign axi_bvalid_out = s_q.bvalid;
    assign axi_bresp_out = s_q.bresp;
    assign axi_rvalid_out = s_q.rvalid;
    assign axi_rdata_out = {24'h00_0000, s_q.rdata};
    assign axi_rresp_out = s_q.rresp;
    assign conv_start_out = s_q.cmd[`PCSR_CMD_CONV];
    assign conversion_result_reload_out = s_q.cmd[`PCSR_CMD_RELOAD];
    assign charge_counters_clear_out = s_q.cmd[`PCSR_CMD_CCLR];
    assign charge_cal_go_out = s_q.cmd[`PCSR_CMD_CAL];
    assign fuse_reload_out = s_q.cmd[`PCSR_CMD_FUSE];
    assign full_reset_out = s_q.cmd[`PCSR_CMD_RESET];
    assign cal_active_out = s_q.cal_st == pcsr_pkg::PCSR_C_RUN;
    // The load is applied only while calibration runs.
    assign cal_load_target_out = cal_active_out ? s_q.cal_setup[`PCSR_CAL_TGT] : 2'h0;
    assign cal_load_level_out = cal_active_out ? s_q.cal_setup[`PCSR_CAL_LVL] : 3'h0;
    assign cal_load_high_out = cal_active_out && s_q.cal_setup[`PCSR_LVL_HIGH];
    assign cal_goal = pulse_goal(s_q.cal_setup[`PCSR_CAL_EXP]);
    assign wr_fire = s_q.aw_got && s_q.w_got;
    // A read that is still only offered already freezes the report.
    assign mode_freeze = axi_arvalid_in && (idx_of(axi_araddr_in) == `PCSR_IDX_MODE);

    always_comb begin
        live_view = 8'h00;
        live_view[`PCSR_LIVE_CAL] = cal_active_out;
        live_view[`PCSR_LIVE_HOT] = s_q.hot;
        live_view[`PCSR_LIVE_LOW] = s_q.low;
        live_view[`PCSR_LIVE_C] = linear_reg_c_en_in && !parallel_c_with_a_in &&
            s_q.sync2[`PCSR_SY_C];
        live_view[`PCSR_LIVE_B] = switcher_b_en_in && s_q.sync2[`PCSR_SY_B];
        live_view[`PCSR_LIVE_A] = switcher_a_en_in && s_q.sync2[`PCSR_SY_A];
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        s_d.cmd = 8'h00;
        s_d.sync1 = {rail_a_converter_mode_pin_in, rail_b_converter_mode_pin_in,
            aux_supply_pin_in, cal_pulse_pin_in, rail_c_regulating_pin_in,
            rail_b_regulating_pin_in, rail_a_regulating_pin_in, supply_low_pin_in,
            overheat_pin_in};
        s_d.sync2 = s_q.sync1;
        s_d.pulse_q = s_q.sync2[`PCSR_SY_PULSE];
        // Comparators are only sampled while periodic conversions run.
        if (sampling_period_in != 8'h00) begin
            s_d.hot = s_q.sync2[`PCSR_SY_HOT];
            s_d.low = s_q.sync2[`PCSR_SY_LOW];
        end
        if (!mode_freeze) begin
            s_d.mode = {s_q.sync2[`PCSR_SY_MB], s_q.sync2[`PCSR_SY_MA]};
        end
        // The flag is taken once the synchroniser holds a real pin value.
        if (!s_q.sc_taken) begin
            if (s_q.settle == `PCSR_SETTLE_N) begin
                s_d.sc_flag = s_q.sync2[`PCSR_SY_AUX];
                s_d.sc_taken = 1'b1;
            end else begin
                s_d.settle = s_q.settle + 2'h1;
            end
        end
        // Raw pulses are counted, never the prescaled count.
        case (s_q.cal_st)
            pcsr_pkg::PCSR_C_IDLE: begin
                if (s_q.cmd[`PCSR_CMD_CAL]) begin
                    s_d.cal_st = pcsr_pkg::PCSR_C_RUN;
                    s_d.cal_count = 9'h000;
                end
            end
            pcsr_pkg::PCSR_C_RUN: begin
                if (s_q.cal_count >= cal_goal) begin
                    s_d.cal_st = pcsr_pkg::PCSR_C_IDLE;
                end else if (s_q.sync2[`PCSR_SY_PULSE] && !s_q.pulse_q) begin
                    s_d.cal_count = s_q.cal_count + 9'h001;
                end
            end
            default: begin
                s_d.cal_st = pcsr_pkg::PCSR_C_IDLE;
            end
        endcase
        case (s_q.fuse_st)
            pcsr_pkg::PCSR_F_IDLE: begin
            end
            pcsr_pkg::PCSR_F_READ: begin
                s_d.fuse_st = pcsr_pkg::PCSR_F_TAKE;
            end
            pcsr_pkg::PCSR_F_TAKE: begin
                s_d.fuse_data = fuse_rd_data;
                s_d.fuse_st = pcsr_pkg::PCSR_F_IDLE;
            end
            default: begin
                s_d.fuse_st = pcsr_pkg::PCSR_F_IDLE;
            end
        endcase
        // A reload restores defaults and reads the fuses afresh.
        if (s_q.cmd[`PCSR_CMD_FUSE]) begin
            s_d.cal_setup = `PCSR_CAL_RST;
            s_d.fuse_addr = `PCSR_FADDR_RST;
            s_d.fuse_st = pcsr_pkg::PCSR_F_READ;
        end
        // Write address and data may come in either order.
        if (axi_awvalid_in && axi_awready_out) begin
            s_d.aw_got = 1'b1;
            s_d.aw_idx = idx_of(axi_awaddr_in);
        end
        if (axi_wvalid_in && axi_wready_out) begin
            s_d.w_got = 1'b1;
            s_d.w_data = axi_wdata_in[7:0];
            s_d.w_en = axi_wstrb_in[0];
        end
        if (wr_fire) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = is_mapped(s_q.aw_idx) ? `PCSR_RESP_OKAY : `PCSR_RESP_SLVERR;
            if (s_q.w_en) begin
                case (s_q.aw_idx)
                    `PCSR_IDX_CAL: begin
                        s_d.cal_setup = s_q.w_data;
                    end
                    `PCSR_IDX_FADDR: begin
                        s_d.fuse_addr = s_q.w_data[`PCSR_FADDR_F];
                    end
                    `PCSR_IDX_FSTAT: begin
                        if (s_q.w_data[`PCSR_FSTAT_GO] &&
                                s_q.fuse_st == pcsr_pkg::PCSR_F_IDLE) begin
                            s_d.fuse_st = pcsr_pkg::PCSR_F_READ;
                        end
                    end
                    `PCSR_IDX_CMD: begin
                        s_d.cmd = s_q.w_data & `PCSR_CMD_MASK;
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (s_q.bvalid && axi_bready_in) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.rvalid && axi_rready_in) begin
            s_d.rvalid = 1'b0;
        end
        if (axi_arvalid_in && axi_arready_out) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = is_mapped(idx_of(axi_araddr_in)) ? `PCSR_RESP_OKAY :
                `PCSR_RESP_SLVERR;
            case (idx_of(axi_araddr_in))
                `PCSR_IDX_LIVE: s_d.rdata = live_view;
                `PCSR_IDX_ID: s_d.rdata = {REVISION_CODE, PART_CODE};
                `PCSR_IDX_CAL: s_d.rdata = s_q.cal_setup;
                `PCSR_IDX_FADDR: s_d.rdata = {1'b0, s_q.fuse_addr};
                `PCSR_IDX_FDATA: s_d.rdata = s_q.fuse_data;
                `PCSR_IDX_FSTAT: begin
                    s_d.rdata = 8'h00;
                    s_d.rdata[`PCSR_FSTAT_BUSY] = s_q.fuse_st != pcsr_pkg::PCSR_F_IDLE;
                end
                `PCSR_IDX_MODE: begin
                    s_d.rdata = 8'h00;
                    s_d.rdata[`PCSR_MODE_SC] = s_q.sc_flag;
                    s_d.rdata[`PCSR_MODE_B] = s_q.mode[2];
                    s_d.rdata[`PCSR_MODE_A] = s_q.mode[1:0];
                end
                default: s_d.rdata = 8'h00;
            endcase
        end
        // A forced reset clears calibration, fuse register, comparator and single-cell state, not the mode report, and lets the bus finish.
        if (s_q.cmd[`PCSR_CMD_RESET]) begin
            s_d.cal_setup = `PCSR_CAL_RST;
            s_d.fuse_addr = `PCSR_FADDR_RST;
            s_d.fuse_data = `PCSR_FDATA_RST;
            s_d.fuse_st = pcsr_pkg::PCSR_F_IDLE;
            s_d.cal_st = pcsr_pkg::PCSR_C_IDLE;
            s_d.cal_count = 9'h000;
            s_d.hot = 1'b0;
            s_d.low = 1'b0;
            s_d.sc_taken = 1'b0;
            s_d.sc_flag = 1'b0;
            s_d.settle = 2'h0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    sequence s_cmd_write(int b);
        wr_fire && s_q.w_en && s_q.aw_idx == `PCSR_IDX_CMD && s_q.w_data[b];
    endsequence

    sequence s_fuse_start;
        wr_fire && s_q.w_en && s_q.aw_idx == `PCSR_IDX_FSTAT &&
            s_q.w_data[`PCSR_FSTAT_GO] && s_q.fuse_st == pcsr_pkg::PCSR_F_IDLE &&
            !s_q.cmd[`PCSR_CMD_RESET];
    endsequence

    sequence s_fuse_busy_then_done;
        s_q.fuse_st != pcsr_pkg::PCSR_F_IDLE [*2] ##1 s_q.fuse_st == pcsr_pkg::PCSR_F_IDLE;
    endsequence

    property p_conv_pulse;
        s_cmd_write(7) |=> conv_start_out ##1 !conv_start_out;
    endproperty
    a_conv_pulse: assert property (p_conv_pulse)
        else $error("conversion start not a one-cycle pulse");

    property p_clear_pulse;
        s_cmd_write(5) |=> charge_counters_clear_out;
    endproperty
    a_clear_pulse: assert property (p_clear_pulse)
        else $error("counter clear not issued");

    property p_cal_start;
        s_cmd_write(4) ##0 !cal_active_out && !s_q.w_data[`PCSR_CMD_RESET] |=> ##1
            cal_active_out;
    endproperty
    a_cal_start: assert property (p_cal_start)
        else $error("calibration did not start");

    property p_cal_done;
        cal_active_out && s_q.cal_count >= cal_goal && !full_reset_out |=> !cal_active_out;
    endproperty
    a_cal_done: assert property (p_cal_done)
        else $error("calibration ran past its pulse goal");

    property p_fuse_busy;
        s_fuse_start |=> s_fuse_busy_then_done;
    endproperty
    a_fuse_busy: assert property (p_fuse_busy)
        else $error("fuse busy window wrong");

    property p_fuse_data;
        s_q.fuse_st == pcsr_pkg::PCSR_F_TAKE && !full_reset_out |=>
            s_q.fuse_data == $past(fuse_rd_data);
    endproperty
    a_fuse_data: assert property (p_fuse_data)
        else $error("fuse data not captured");

    property p_mode_freeze;
        mode_freeze |=> s_q.mode == $past(s_q.mode);
    endproperty
    a_mode_freeze: assert property (p_mode_freeze)
        else $error("mode report changed while addressed");

    property p_hot_hold;
        sampling_period_in == 8'h00 && !full_reset_out |=> $stable(s_q.hot) && $stable(s_q.low);
    endproperty
    a_hot_hold: assert property (p_hot_hold)
        else $error("live comparator bits refreshed with sampling off");

    property p_soft_reset;
        full_reset_out |=> s_q.cal_setup == `PCSR_CAL_RST && !cal_active_out &&
            s_q.fuse_data == `PCSR_FDATA_RST;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("forced reset left state behind");

    property p_sc_latch;
        s_q.sc_taken && !full_reset_out |=> $stable(s_q.sc_flag);
    endproperty
    a_sc_latch: assert property (p_sc_latch)
        else $error("single-cell flag changed after latching");
endmodule // pcsr_regs

// file: pcsr_consts.svh
`ifndef PCSR_CONSTS_SVH
`define PCSR_CONSTS_SVH
// Register indices; the byte address is four times the index.
`define PCSR_IDX_LIVE 8'h04
`define PCSR_IDX_ID 8'h05
`define PCSR_IDX_CAL 8'h0A
`define PCSR_IDX_FADDR 8'h0B
`define PCSR_IDX_FDATA 8'h0C
`define PCSR_IDX_FSTAT 8'h0E
`define PCSR_IDX_CMD 8'h10
`define PCSR_IDX_MODE 8'h12
`define PCSR_IDX_MSB 9
`define PCSR_IDX_LSB 2
// Live status bits.
`define PCSR_LIVE_CAL 5
`define PCSR_LIVE_HOT 4
`define PCSR_LIVE_LOW 3
`define PCSR_LIVE_C 2
`define PCSR_LIVE_B 1
`define PCSR_LIVE_A 0
// Calibration setup fields.
`define PCSR_CAL_EXP 7:5
`define PCSR_CAL_TGT 4:3
`define PCSR_CAL_LVL 2:0
`define PCSR_LVL_HIGH 2
// Fuse address, status and control.
`define PCSR_FADDR_F 6:0
`define PCSR_FSTAT_BUSY 3
`define PCSR_FSTAT_GO 2
// Command bits.
`define PCSR_CMD_CONV 7
`define PCSR_CMD_RELOAD 6
`define PCSR_CMD_CCLR 5
`define PCSR_CMD_CAL 4
`define PCSR_CMD_FUSE 2
`define PCSR_CMD_RESET 0
`define PCSR_CMD_MASK 8'hF5
// Mode report bits.
`define PCSR_MODE_SC 3
`define PCSR_MODE_B 2
`define PCSR_MODE_A 1:0
// Synchroniser lanes.
`define PCSR_SY_HOT 0
`define PCSR_SY_LOW 1
`define PCSR_SY_A 2
`define PCSR_SY_B 3
`define PCSR_SY_C 4
`define PCSR_SY_PULSE 5
`define PCSR_SY_AUX 6
`define PCSR_SY_MB 7
`define PCSR_SY_MA 9:8
// Reset values and answers.
`define PCSR_CAL_RST 8'h00
`define PCSR_FADDR_RST 7'h00
`define PCSR_FDATA_RST 8'h00
`define PCSR_SETTLE_N 2'h2
`define PCSR_RESP_OKAY 2'h0
`define PCSR_RESP_SLVERR 2'h2
`endif

// file: pcsr_pkg.sv
package pcsr_pkg;
    typedef enum logic [1:0] {
        PCSR_F_IDLE = 2'h0,
        PCSR_F_READ = 2'h1,
        PCSR_F_TAKE = 2'h3
    } pcsr_fuse_st_t;

    typedef enum logic [1:0] {
        PCSR_C_IDLE = 2'h0,
        PCSR_C_RUN = 2'h1
    } pcsr_cal_st_t;

    typedef struct packed {
        logic [9:0] sync1;
        logic [9:0] sync2;
        logic aw_got;
        logic [7:0] aw_idx;
        logic w_got;
        logic w_en;
        logic [7:0] w_data;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] cal_setup;
        logic [6:0] fuse_addr;
        logic [7:0] fuse_data;
        pcsr_fuse_st_t fuse_st;
        pcsr_cal_st_t cal_st;
        logic [8:0] cal_count;
        logic pulse_q;
        logic hot;
        logic low;
        logic sc_flag;
        logic sc_taken;
        logic [1:0] settle;
        logic [2:0] mode;
        logic [7:0] cmd;
    } pcsr_state_t;
endpackage

// file: pcsr_fuse_mem.sv
`timescale 1ns/100ps
module pcsr_fuse_mem #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Burn port.
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [DW-1:0] wr_data_in,
    // Read port.
    input wire logic rd_en_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [DW-1:0] rd_data_out
);
    // Unburnt fuses read as zero, so the array clears only on the pin reset.
    logic [DW-1:0] mem_q [2**AW];

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < 2**AW; i++) begin
                mem_q[i] <= '0;
            end
            rd_data_out <= '0;
        end else begin
            if (wr_en_in) begin
                mem_q[wr_addr_in] <= wr_data_in;
            end
            if (rd_en_in) begin
                rd_data_out <= mem_q[rd_addr_in];
            end
        end
    end
endmodule // pcsr_fuse_mem

// file: pcsr_host.sv
`timescale 1ns/100ps
module pcsr_host (
    // Clock.
    input wire logic clk_in,
    // Write side.
    output logic awvalid_out,
    input wire logic awready_in,
    output logic [11:0] awaddr_out,
    output logic wvalid_out,
    input wire logic wready_in,
    output logic [31:0] wdata_out,
    input wire logic bvalid_in,
    output logic bready_out,
    // Read side.
    output logic arvalid_out,
    input wire logic arready_in,
    output logic [11:0] araddr_out,
    input wire logic rvalid_in,
    output logic rready_out
);
    initial begin
        {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = 5'h0;
        {awaddr_out, araddr_out, wdata_out} = 56'h0;
    end
    // Callers always send reserved bits as zero.
    task automatic write(input logic [11:0] a, input logic [31:0] d, output bit ok);
        ok = 1'b0;
        @(posedge clk_in);
        awaddr_out <= a;
        wdata_out <= d;
        awvalid_out <= 1'b1;
        wvalid_out <= 1'b1;
        bready_out <= 1'b1;
        for (int i = 0; i < 40 && !ok; i++) begin
            @(posedge clk_in);
            // Released lines carry the inverse so stale values cannot pass.
            if (awready_in) begin
                awvalid_out <= 1'b0;
                awaddr_out <= ~a;
            end
            if (wready_in) begin
                wvalid_out <= 1'b0;
                wdata_out <= ~d;
            end
            if (bvalid_in) begin
                bready_out <= 1'b0;
                ok = 1'b1;
            end
        end
    endtask
    task automatic read(input logic [11:0] a, output bit ok);
        ok = 1'b0;
        @(posedge clk_in);
        araddr_out <= a;
        arvalid_out <= 1'b1;
        rready_out <= 1'b1;
        for (int i = 0; i < 40 && !ok; i++) begin
            @(posedge clk_in);
            if (arready_in) begin
                arvalid_out <= 1'b0;
                araddr_out <= ~a;
            end
            if (rvalid_in) begin
                rready_out <= 1'b0;
                ok = 1'b1;
            end
        end
    endtask
endmodule // pcsr_host

// file: tb.sv
`timescale 1ns/100ps
`include "pcsr_consts.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
    logic clk_in = 0, rst_b_in = 0, axi_awvalid_in, axi_awready_out, axi_wvalid_in;
    logic axi_wready_out, axi_bvalid_out, axi_bready_in, axi_arvalid_in, axi_arready_out;
    logic axi_rvalid_out, axi_rready_in, fuse_prog_en_in = 0, conv_start_out, full_reset_out;
    logic conversion_result_reload_out, charge_counters_clear_out, charge_cal_go_out;
    logic fuse_reload_out, cal_active_out, cal_load_high_out, ok;
    logic [11:0] axi_awaddr_in, axi_araddr_in;
    logic [31:0] axi_wdata_in, axi_rdata_out, seed = 32'h0000_4DD8;
    logic [1:0] axi_bresp_out, axi_rresp_out, cal_load_target_out;
    logic [2:0] cal_load_level_out;
    logic [7:0] samp = 8'h00, fuse_prog_data_in = 8'h00, x;
    logic [3:0] en = 4'hB;
    logic [9:0] pin = 10'h2C0;
    logic [33:0] expq[$];
    int err_total = 0, cmp_count = 0, pc[6] = '{default: 0};
    wire [5:0] pl = {conv_start_out, conversion_result_reload_out, charge_counters_clear_out,
        charge_cal_go_out, fuse_reload_out, full_reset_out};
    initial forever #25 clk_in = ~clk_in;
    pcsr_regs #(.REVISION_CODE(3'h5), .PART_CODE(5'h13)) dut (.clk_in, .rst_b_in,
        .axi_awvalid_in, .axi_awready_out, .axi_awaddr_in, .axi_wvalid_in, .axi_wready_out,
        .axi_wdata_in, .axi_wstrb_in(4'hF), .axi_bvalid_out, .axi_bready_in, .axi_bresp_out,
        .axi_arvalid_in, .axi_arready_out, .axi_araddr_in, .axi_rvalid_out, .axi_rready_in,
        .axi_rdata_out, .axi_rresp_out, .sampling_period_in(samp), .linear_reg_c_en_in(en[3]),
        .parallel_c_with_a_in(en[2]), .switcher_a_en_in(en[1]), .switcher_b_en_in(en[0]),
        .overheat_pin_in(pin[0]), .supply_low_pin_in(pin[1]), .rail_a_regulating_pin_in(pin[2]),
        .rail_b_regulating_pin_in(pin[3]), .rail_c_regulating_pin_in(pin[4]),
        .cal_pulse_pin_in(pin[5]), .aux_supply_pin_in(pin[6]),
        .rail_b_converter_mode_pin_in(pin[7]), .rail_a_converter_mode_pin_in(pin[9:8]),
        .fuse_prog_en_in, .fuse_prog_data_in, .conv_start_out, .conversion_result_reload_out,
        .charge_counters_clear_out, .charge_cal_go_out, .fuse_reload_out, .full_reset_out,
        .cal_active_out, .cal_load_target_out, .cal_load_level_out, .cal_load_high_out);
    pcsr_host h (.clk_in, .awvalid_out(axi_awvalid_in), .awready_in(axi_awready_out),
        .awaddr_out(axi_awaddr_in), .wvalid_out(axi_wvalid_in), .wready_in(axi_wready_out),
        .wdata_out(axi_wdata_in), .bvalid_in(axi_bvalid_out), .bready_out(axi_bready_in),
        .arvalid_out(axi_arvalid_in), .arready_in(axi_arready_out),
        .araddr_out(axi_araddr_in), .rvalid_in(axi_rvalid_out), .rready_out(axi_rready_in));
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_in) begin
        for (int k = 0; k < 6; k++) pc[k] += int'(pl[k]);
        if (axi_bvalid_out && axi_bready_in) chk({axi_bresp_out, 32'h0});
        if (axi_rvalid_out && axi_rready_in) chk({axi_rresp_out, axi_rdata_out});
    end
    task automatic chk(input logic [33:0] g);
        if (expq.size() == 0) begin
            `CHK(g, 34'h0)
        end else begin
            `CHK(g, expq.pop_front())
        end
    endtask
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0 && expq.size() == 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] r = 2'h0);
        expq.push_back({r, 32'h0});
        h.write({2'b00, i, 2'b00}, {24'h0, d}, ok);
        if (!ok) begin
            err_total++;
            wrap_up();
        end
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        expq.push_back({`PCSR_RESP_OKAY, 24'h0, e});
        h.read({2'b00, i, 2'b00}, ok);
        if (!ok) begin
            err_total++;
            wrap_up();
        end
    endtask
    // Each command bit must give exactly one pulse on its own output.
    task automatic cmd(input int ix, input int b);
        int pre[6];
        pre = pc;
        wr(`PCSR_IDX_CMD, 8'(1 << b));
        repeat (3) @(posedge clk_in);
        for (int k = 0; k < 6; k++) `CHK(pc[k] - pre[k], int'(k == ix))
    endtask
    task automatic pulse();
        pin[5] <= 1'b1;
        repeat (2) @(posedge clk_in);
        pin[5] <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        rd(`PCSR_IDX_ID, 8'hB3);
        rd(`PCSR_IDX_CAL, `PCSR_CAL_RST);
        rd(`PCSR_IDX_FDATA, `PCSR_FDATA_RST);
        rd(`PCSR_IDX_CMD, 8'h00);
        rd(`PCSR_IDX_MODE, 8'h0E);
        wr(8'h0F, 8'h00, `PCSR_RESP_SLVERR);
        x = xs();
        wr(`PCSR_IDX_CAL, x);
        rd(`PCSR_IDX_CAL, x);
        samp <= 8'h10;
        pin[4:0] <= 5'h15;
        repeat (4) @(posedge clk_in);
        rd(`PCSR_IDX_LIVE, 8'h15);
        samp <= 8'h00; // Automatic sampling off.
        pin[1:0] <= 2'h2;
        en <= 4'hD;
        repeat (4) @(posedge clk_in);
        rd(`PCSR_IDX_LIVE, 8'h10);
        cmd(5, 7);
        cmd(4, 6);
        cmd(3, 5);
        wr(`PCSR_IDX_CAL, 8'h35);
        cmd(2, 4);
        `CHK({cal_active_out, cal_load_target_out, cal_load_level_out, cal_load_high_out},
            7'h6B)
        rd(`PCSR_IDX_LIVE, 8'h30);
        repeat (3) pulse();
        repeat (6) @(posedge clk_in);
        `CHK(cal_active_out, 1'b1)
        pulse();
        repeat (6) @(posedge clk_in);
        `CHK(cal_active_out, 1'b0)
        x = xs();
        wr(`PCSR_IDX_FADDR, 8'h05);
        fuse_prog_data_in <= x;
        fuse_prog_en_in <= 1'b1;
        @(posedge clk_in);
        fuse_prog_en_in <= 1'b0;
        wr(`PCSR_IDX_FSTAT, 8'h04);
        repeat (4) @(posedge clk_in);
        rd(`PCSR_IDX_FDATA, x);
        rd(`PCSR_IDX_FSTAT, 8'h00);
        rd(`PCSR_IDX_FADDR, 8'h05);
        cmd(1, 2);
        repeat (4) @(posedge clk_in);
        rd(`PCSR_IDX_CAL, 8'h00);
        rd(`PCSR_IDX_FADDR, 8'h00);
        wr(`PCSR_IDX_CAL, 8'h35);
        cmd(0, 0);
        rd(`PCSR_IDX_CAL, 8'h00);
        @(posedge clk_in);
        wrap_up();
    end
endmodule // tb
